// file: reader_timers_consts.vh
// Constants for the reader protocol timer block: register map, fields, resets, steps
`ifndef READER_TIMERS_CONSTS_VH
`define READER_TIMERS_CONSTS_VH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_MRT 8'h04
`define ADDR_NRT 8'h08
`define ADDR_GPT 8'h0c
`define ADDR_WUT 8'h10
`define ADDR_CMD 8'h14
`define ADDR_FLAGS 8'h18
`define ADDR_STATUS 8'h1c
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_NRT_UNCOND 0
`define CTRL_NRT_STEP 1
`define CTRL_GPT_TRIG_LO 2
`define CTRL_GPT_TRIG_HI 3
`define CTRL_SQUELCH_EN 4
`define CTRL_WIDTH 5
`define CTRL_RESET 5'h00
// General timer trigger codes
`define GPT_TRIG_NONE 2'h0
`define GPT_TRIG_SOF 2'h1
`define GPT_TRIG_EOF 2'h2
// ----------------------------------------------------------------
// Flag and status bit positions
// ----------------------------------------------------------------
`define FLAG_NRE 0
`define FLAG_GPT 1
`define FLAG_WUT 2
`define FLAG_OSC 3
`define STAT_MRT_RUN 0
`define STAT_NRT_RUN 1
`define STAT_GPT_RUN 2
`define STAT_WUT_RUN 3
`define STAT_OSC_OK 4
`define STAT_RX_WATCH 5
// ----------------------------------------------------------------
// Commands written to the command register
// ----------------------------------------------------------------
`define CMD_CLEAR 8'h01
`define CMD_START_MRT 8'h02
`define CMD_START_NRT 8'h03
`define CMD_START_GPT 8'h04
`define CMD_START_WUT 8'h05
// ----------------------------------------------------------------
// Steps in carrier periods (or RC ticks for the wake-up timer)
// ----------------------------------------------------------------
`define MRT_STEP 12'd64
`define MRT_STEP_LP 12'd512
`define NRT_STEP_SHORT 12'd64
`define NRT_STEP_LONG 12'd4095
`define GPT_STEP 12'd8
`define RC_TICKS_PER_MS 12'd32
// Wake-up periods in ms, selected by a 3-bit code; code 3 after reset
`define WUT_MS_0 16'd10
`define WUT_MS_1 16'd20
`define WUT_MS_2 16'd50
`define WUT_MS_3 16'd100
`define WUT_MS_4 16'd200
`define WUT_MS_5 16'd300
`define WUT_MS_6 16'd400
`define WUT_MS_7 16'd800
`define WUT_SEL_RESET 3'h3
`endif

// file: reader_protocol_timers.v
// Reader protocol timers: mask-receive, no-response, general and wake-up timers
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "reader_timers_consts.vh"
// How it works
// - Clear command stops every timer except the wake-up timer and, in unconditional mode, the no-response timer.
// - Unconditional no-response mode keeps that timer running through Clear.
// - End of transmit EOF starts the no-response timer, and the mask-receive timer outside active peer mode.
// - Mask-receive running holds receive gate low; it never raises an interrupt.
// - Mask-receive running switches squelch on when squelch is enabled.
// - In active peer mode, peer field on starts mask-receive timer.
// - Low-power target mode: command starts mask timer at 512 periods; expiry starts watching.
// - No-response expiry sets its own flag in the flag register.
// - Step-select bit picks 64 or 4096 carrier periods per no-response count.
// - Normal mode: expiry before reply start interrupts and gates receive; reply stops timer.
// - Unconditional mode: expiry always interrupts; gate forced low only when no reply busy.
// - Start no-response command starts or restarts; ignored in active peer mode.
// - Active peer mode: expiry before peer field on raises an interrupt.
// - General timer triggers on SOF or EOF; in peer mode on field off.
// - Every general timer expiry raises an interrupt.
// - Start general timer command starts or restarts it.
// - Wake-up start accepted outside wake-up mode; starts RC clock; expiry sets flag.
// - Crystal stopped in power-down: only the wake-up timer keeps counting.
// - Oscillator-stable bit sets when stable, and an interrupt flag follows.
// - Wake-up periods selectable from 10 ms to 800 ms; 100 ms after reset.

// ----------------------------------------------------------------
// Generic step timer: prescaler of ticks, then a down counter
// ----------------------------------------------------------------
module step_timer (
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire tick,
   input wire start,
   input wire stop,
   input wire [15:0] value,
   input wire [11:0] stepLen,
   output wire running,
   output reg expire
);
   reg runQ;
   reg [11:0] preQ;
   reg [15:0] cntQ;
   reg [11:0] stepQ;
   assign running = runQ;
   // Start wins over stop so a restart in the stop cycle is kept
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         runQ <= 1'b0;
         preQ <= 12'h000;
         cntQ <= 16'h0000;
         stepQ <= 12'h000;
         expire <= 1'b0;
      end else if (ce) begin
         expire <= 1'b0;
         if (start && value != 16'h0000) begin
            runQ <= 1'b1;
            preQ <= 12'h000;
            cntQ <= value;
            stepQ <= stepLen;
         end else if (stop) begin
            runQ <= 1'b0;
         end else if (runQ && tick) begin
            if (preQ == stepQ - 12'h001) begin
               preQ <= 12'h000;
               if (cntQ == 16'h0001) begin
                  runQ <= 1'b0;
                  expire <= 1'b1;
               end
               cntQ <= cntQ - 16'h0001;
            end else begin
               preQ <= preQ + 12'h001;
            end
         end
      end
   end
endmodule

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module reader_protocol_timers (
   input wire clk,
   input wire rstn,
   input wire ce,
   // AHB-Lite slave
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Events from transmitter, framing and field detector (same clock)
   input wire carrierTick,
   input wire txEnd,
   input wire rxSof,
   input wire rxEof,
   input wire rxBusy,
   input wire peerFieldOn,
   input wire peerFieldOff,
   input wire p2pMode,
   input wire lpTargetMode,
   input wire wakeupMode,
   input wire powerDown,
   // Asynchronous inputs from analog blocks
   input wire rcClkIn,
   input wire oscStableIn,
   // Outputs
   output wire rxOn,
   output wire squelchOn,
   output wire rxWatch,
   output wire rcOscEn,
   output reg nreEvent,
   output reg gptEvent,
   output reg wakeupTimerFlag,
   output reg oscEvent
);
   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   reg [`CTRL_WIDTH-1:0] ctrlQ;
   reg [7:0] mrtValQ;
   reg [15:0] nrtValQ;
   reg [15:0] gptValQ;
   reg [2:0] wutSelQ;
   reg [3:0] flagsQ;
   reg rxGateQ;
   reg rxWatchQ;
   reg mrtLpQ;
   reg wrPendQ;
   reg [7:0] wrAddrQ;
   // Synchronisers for the RC clock and the oscillator level
   reg rcS1Q, rcS2Q, rcS3Q;
   reg oscS1Q, oscS2Q, oscS3Q;
   wire mrtRun, nrtRun, gptRun, wutRun;
   wire mrtExp, nrtExp, gptExp, wutExp;
   reg [15:0] wutMs;
   reg [31:0] rdMux;

   // Bus: zero wait states, always OKAY; a frozen block stretches the transfer
   assign hreadyout = ce;
   assign hresp = 1'b0;
   wire addrPhase = hsel && htrans[1] && hready;
   wire wrNow = wrPendQ && ce;
   wire cmdWr = wrNow && wrAddrQ == `ADDR_CMD;
   wire [7:0] cmd = hwdata[7:0];
   wire cmdClear = cmdWr && cmd == `CMD_CLEAR;
   wire nrtUncond = ctrlQ[`CTRL_NRT_UNCOND];
   wire [1:0] gptTrig = ctrlQ[`CTRL_GPT_TRIG_HI:`CTRL_GPT_TRIG_LO];

   // Carrier tick stops with the crystal in power-down
   wire fcTick = carrierTick && !powerDown;
   wire rcEdge = rcS2Q && !rcS3Q;
   wire oscRise = oscS2Q && !oscS3Q;

   // ----------------------------------------------------------------
   // Timer start and stop terms
   // ----------------------------------------------------------------
   wire mrtCmd = cmdWr && cmd == `CMD_START_MRT;
   wire mrtStart = (txEnd && !p2pMode) || (peerFieldOn && p2pMode) || mrtCmd;
   // Low-power target start uses the slow step
   wire mrtLpStart = mrtCmd && lpTargetMode;
   wire [11:0] mrtStep = mrtLpStart ? `MRT_STEP_LP : `MRT_STEP;
   wire nrtStart = txEnd || (cmdWr && cmd == `CMD_START_NRT && !p2pMode);
   // Reply start stops it only in normal mode; peer field ends the wait in peer mode
   wire nrtStop = (cmdClear && !nrtUncond)
      || (rxSof && !nrtUncond && !p2pMode)
      || (peerFieldOn && p2pMode);
   wire [11:0] nrtStep = ctrlQ[`CTRL_NRT_STEP] ? `NRT_STEP_LONG + 12'h001 : `NRT_STEP_SHORT;
   wire gptStart = (p2pMode ? peerFieldOff
      : ((gptTrig == `GPT_TRIG_SOF && rxSof) || (gptTrig == `GPT_TRIG_EOF && rxEof)))
      || (cmdWr && cmd == `CMD_START_GPT);
   wire wutStart = cmdWr && cmd == `CMD_START_WUT && !wakeupMode;
   // Wake-up period in ms for each select code; all eight codes are legal
   always @* begin
      case (wutSelQ)
         3'h0: wutMs = `WUT_MS_0;
         3'h1: wutMs = `WUT_MS_1;
         3'h2: wutMs = `WUT_MS_2;
         3'h3: wutMs = `WUT_MS_3;
         3'h4: wutMs = `WUT_MS_4;
         3'h5: wutMs = `WUT_MS_5;
         3'h6: wutMs = `WUT_MS_6;
         default: wutMs = `WUT_MS_7;
      endcase
   end
   // ----------------------------------------------------------------
   // Timer instances
   // ----------------------------------------------------------------
   step_timer mrtTimer (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .tick(fcTick),
      .start(mrtStart),
      .stop(cmdClear),
      .value({8'h00, mrtValQ}),
      .stepLen(mrtStep),
      .running(mrtRun),
      .expire(mrtExp)
   );
   step_timer nrtTimer (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .tick(fcTick),
      .start(nrtStart),
      .stop(nrtStop),
      .value(nrtValQ),
      .stepLen(nrtStep),
      .running(nrtRun),
      .expire(nrtExp)
   );
   step_timer gptTimer (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .tick(fcTick),
      .start(gptStart),
      .stop(cmdClear),
      .value(gptValQ),
      .stepLen(`GPT_STEP),
      .running(gptRun),
      .expire(gptExp)
   );
   // Wake-up timer counts RC ticks and ignores Clear
   step_timer wutTimer (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .tick(rcEdge),
      .start(wutStart),
      .stop(1'b0),
      .value(wutMs),
      .stepLen(`RC_TICKS_PER_MS),
      .running(wutRun),
      .expire(wutExp)
   );

   // ----------------------------------------------------------------
   // Receive gate, squelch and watch outputs
   // ----------------------------------------------------------------
   assign rxOn = rxGateQ && !mrtRun;
   assign squelchOn = mrtRun && ctrlQ[`CTRL_SQUELCH_EN];
   assign rxWatch = rxWatchQ;
   assign rcOscEn = wutRun;

   // Synchronisers: only the second and third stages feed logic
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rcS1Q <= 1'b0;
         rcS2Q <= 1'b0;
         rcS3Q <= 1'b0;
         oscS1Q <= 1'b0;
         oscS2Q <= 1'b0;
         oscS3Q <= 1'b0;
      end else if (ce) begin
         rcS1Q <= rcClkIn;
         rcS2Q <= rcS1Q;
         rcS3Q <= rcS2Q;
         oscS1Q <= oscStableIn;
         oscS2Q <= oscS1Q;
         oscS3Q <= oscS2Q;
      end
   end

   // Gate is reopened by a new transmission; forced low on a no-response timeout except in unconditional mode with rxBusy set
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rxGateQ <= 1'b1;
         rxWatchQ <= 1'b0;
         mrtLpQ <= 1'b0;
      end else if (ce) begin
         if (nrtExp && (!nrtUncond || !rxBusy)) begin
            rxGateQ <= 1'b0;
         end else if (txEnd) begin
            rxGateQ <= 1'b1;
         end
         if (mrtStart) begin
            mrtLpQ <= mrtLpStart;
         end
         if (mrtExp && mrtLpQ) begin
            rxWatchQ <= 1'b1;
         end else if (mrtStart || cmdClear) begin
            rxWatchQ <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Event pulses and sticky flags; a set beats a clear in the same cycle
   // ----------------------------------------------------------------
   wire flagWr = wrNow && wrAddrQ == `ADDR_FLAGS;
   wire [3:0] flagSet = {oscRise, wutExp, gptExp, nrtExp};
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flagsQ <= 4'h0;
         nreEvent <= 1'b0;
         gptEvent <= 1'b0;
         wakeupTimerFlag <= 1'b0;
         oscEvent <= 1'b0;
      end else if (ce) begin
         flagsQ <= (flagsQ & ~(flagWr ? hwdata[3:0] : 4'h0)) | flagSet;
         nreEvent <= nrtExp;
         gptEvent <= gptExp;
         oscEvent <= oscRise;
         if (wutExp) begin
            wakeupTimerFlag <= 1'b1;
         end else if (flagWr && hwdata[`FLAG_WUT]) begin
            wakeupTimerFlag <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Bus slave: address phase captured, write data taken in data phase
   // ----------------------------------------------------------------
   always @* begin
      case (haddr)
         `ADDR_CTRL: rdMux = {27'h0, ctrlQ};
         `ADDR_MRT: rdMux = {24'h000000, mrtValQ};
         `ADDR_NRT: rdMux = {16'h0000, nrtValQ};
         `ADDR_GPT: rdMux = {16'h0000, gptValQ};
         `ADDR_WUT: rdMux = {29'h0, wutSelQ};
         `ADDR_FLAGS: rdMux = {28'h0000000, flagsQ};
         `ADDR_STATUS: rdMux = {26'h0, rxWatchQ, oscS2Q, wutRun, gptRun, nrtRun, mrtRun};
         default: rdMux = 32'h00000000;
      endcase
   end

   // Setup registers accept any write; the host keeps them still while a timer runs
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrPendQ <= 1'b0;
         wrAddrQ <= 8'h00;
         hrdata <= 32'h00000000;
         ctrlQ <= `CTRL_RESET;
         mrtValQ <= 8'h00;
         nrtValQ <= 16'h0000;
         gptValQ <= 16'h0000;
         wutSelQ <= `WUT_SEL_RESET;
      end else if (ce) begin
         wrPendQ <= addrPhase && hwrite;
         wrAddrQ <= haddr;
         if (addrPhase && !hwrite) begin
            hrdata <= rdMux;
         end
         if (wrNow) begin
            case (wrAddrQ)
               `ADDR_CTRL: ctrlQ <= hwdata[`CTRL_WIDTH-1:0];
               `ADDR_MRT: mrtValQ <= hwdata[7:0];
               `ADDR_NRT: nrtValQ <= hwdata[15:0];
               `ADDR_GPT: gptValQ <= hwdata[15:0];
               `ADDR_WUT: wutSelQ <= hwdata[2:0];
               default: wrAddrQ <= wrAddrQ;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: reader_protocol_timers_assertions.sv
// Port checker for the reader protocol timer block
`timescale 1ns/10ps
`default_nettype none
module reader_protocol_timers_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic txEnd,
   input wire logic rxBusy,
   input wire logic lpTargetMode,
   input wire logic rxOn,
   input wire logic squelchOn,
   input wire logic rxWatch,
   input wire logic rcOscEn,
   input wire logic nreEvent,
   input wire logic gptEvent,
   input wire logic wakeupTimerFlag,
   input wire logic oscEvent
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // A timeout with no reply in flight must leave the receive gate closed
   property p_nre_gate;
      nreEvent && !$past(rxBusy, 2) && !$past(txEnd) |-> !rxOn;
   endproperty
   a_nre_gate: assert property (p_nre_gate)
      else $error("receive gate open at no-response timeout");
   // Squelch only comes on while the mask timer blocks the receiver
   property p_sq_mask;
      squelchOn |-> !rxOn;
   endproperty
   a_sq_mask: assert property (p_sq_mask)
      else $error("squelch on while receive gate open");
   property p_nre_pulse;
      nreEvent |=> !nreEvent;
   endproperty
   a_nre_pulse: assert property (p_nre_pulse)
      else $error("no-response event longer than one cycle");
   property p_gpt_pulse;
      gptEvent |=> !gptEvent;
   endproperty
   a_gpt_pulse: assert property (p_gpt_pulse)
      else $error("general timer event longer than one cycle");
   // Wake-up flag can only follow a running wake-up timer
   property p_wut_flag;
      $rose(wakeupTimerFlag) |-> $past(rcOscEn, 2);
   endproperty
   a_wut_flag: assert property (p_wut_flag)
      else $error("wake-up flag without running timer");
   // Crystal-stable event is a single notice, not a stream
   property p_osc_once;
      oscEvent |=> !oscEvent [*8];
   endproperty
   a_osc_once: assert property (p_osc_once)
      else $error("repeated crystal-stable event");
   property p_watch_lp;
      $rose(rxWatch) |-> lpTargetMode;
   endproperty
   a_watch_lp: assert property (p_watch_lp)
      else $error("receiver watch outside low-power target mode");
   // Unmapped reads return zero with an OKAY response
   property p_unmapped;
      hsel && htrans[1] && !hwrite && hready && ce && haddr > 8'h1f |=> hrdata == 32'h0 && !hresp;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
endmodule
bind reader_protocol_timers reader_protocol_timers_chk i_chk (.clk, .rstn, .ce, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hresp, .hrdata, .txEnd, .rxBusy, .lpTargetMode, .rxOn,
   .squelchOn, .rxWatch, .rcOscEn, .nreEvent, .gptEvent, .wakeupTimerFlag, .oscEvent);
`default_nettype wire

// file: frontend_model.sv
// Model of the analog front end: carrier ticks, RC clock and crystal status
`timescale 1ns/10ps
`default_nettype none
module frontend_model (
   input wire logic clk,
   input wire logic rstn,
   output logic carrierTick,
   output logic rcClkIn,
   output logic oscStableIn
);
   int cnt;
   // One tick per clock keeps step counts equal to cycles; RC runs free at a quarter rate
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         carrierTick <= 1'b0;
         rcClkIn <= 1'b0;
         oscStableIn <= 1'b0;
      end else begin
         cnt <= cnt + 1;
         carrierTick <= 1'b1;
         rcClkIn <= cnt[1];
         oscStableIn <= (cnt > 100); // Crystal settles after a while
      end
   end
endmodule
`default_nettype wire

// file: reader_protocol_timers_tb.sv
// Testbench for the reader protocol timer block
`timescale 1ns/10ps
`default_nettype none
`include "reader_timers_consts.vh"
module reader_protocol_timers_tb;
   logic clk, rstn, ce, hsel, hwrite, txEnd, rxSof, rxEof, rxBusy, peerFieldOn, peerFieldOff;
   logic p2pMode, lpTargetMode, wakeupMode, powerDown, carrierTick, rcClkIn, oscStableIn;
   logic hreadyout, hresp, rxOn, squelchOn, rxWatch, rcOscEn, nreEvent, gptEvent;
   logic wakeupTimerFlag, oscEvent;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [2:0] evs;
   int n_mismatch = 0, checks = 0, cyc = 0, n;
   assign evs = {wakeupTimerFlag, gptEvent, nreEvent};
   reader_protocol_timers i_dut (.clk, .rstn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .carrierTick, .txEnd, .rxSof,
      .rxEof, .rxBusy, .peerFieldOn, .peerFieldOff, .p2pMode, .lpTargetMode, .wakeupMode,
      .powerDown, .rcClkIn, .oscStableIn, .rxOn, .squelchOn, .rxWatch, .rcOscEn, .nreEvent,
      .gptEvent, .wakeupTimerFlag, .oscEvent);
   frontend_model i_fe (.clk, .rstn, .carrierTick, .rcClkIn, .oscStableIn);
   // Free-running 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Hang guard, well beyond the roughly 6700 cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic close_out;
      if (n_mismatch == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int got, input int lo, input int hi);
      checks++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("Error at %0t: count %h outside %h to %h", $time, got, lo, hi);
      end
   endtask
   // One AHB single transfer; no fixed latency is assumed, hready is awaited
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task automatic pulse_tx;
      txEnd <= 1'b1;
      @(posedge clk);
      txEnd <= 1'b0;
   endtask
   // Count cycles until the chosen event shows, giving up at the limit
   task automatic wait_ev(input int sel, input int lim);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (evs[sel] !== 1'b1 && n < lim);
   endtask
   // Main sequence
   initial begin
      {rstn, hsel, hwrite, txEnd, rxSof, rxEof, rxBusy, peerFieldOn, peerFieldOff} = 9'h0;
      {p2pMode, lpTargetMode, wakeupMode, powerDown, haddr, htrans, hsize} = 17'h0;
      hwdata = 32'h0;
      ce = 1'b1;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rdc(`ADDR_CTRL, 32'hffffffff, 32'h0);
      rdc(`ADDR_WUT, 32'h7, 32'h3);
      rdc(8'h20, 32'hffffffff, 32'h0);
      wr(`ADDR_MRT, 32'h1);
      wr(`ADDR_NRT, 32'h2);
      wr(`ADDR_CTRL, 32'h10);
      pulse_tx();
      rdc(`ADDR_STATUS, 32'h3, 32'h3);
      chk(rxOn, 1'b0);
      chk(squelchOn, 1'b1);
      repeat (70) @(posedge clk);
      chk(rxOn, 1'b1);
      wait_ev(0, 200);
      chk_rng(n + 73, 120, 132);
      chk(rxOn, 1'b0);
      rdc(`ADDR_FLAGS, 32'h1, 32'h1);
      wr(`ADDR_FLAGS, 32'h1);
      pulse_tx();
      repeat (80) @(posedge clk);
      rxSof <= 1'b1;
      @(posedge clk);
      rxSof <= 1'b0;
      wait_ev(0, 200);
      chk_rng(n, 200, 200);
      chk(rxOn, 1'b1);
      wr(`ADDR_CTRL, 32'h11);
      rxBusy <= 1'b1;
      pulse_tx();
      wr(`ADDR_CMD, `CMD_CLEAR);
      rdc(`ADDR_STATUS, 32'h3, 32'h2);
      wait_ev(0, 200);
      chk_rng(n, 115, 128);
      chk(rxOn, 1'b1);
      rxBusy <= 1'b0;
      wr(`ADDR_CTRL, 32'h0);
      wr(`ADDR_GPT, 32'h3);
      wr(`ADDR_CMD, `CMD_START_GPT);
      repeat (10) @(posedge clk);
      wr(`ADDR_CMD, `CMD_START_GPT);
      wait_ev(1, 100);
      chk_rng(n, 22, 27);
      wr(`ADDR_GPT, 32'h0);
      wr(`ADDR_CMD, `CMD_START_GPT);
      rdc(`ADDR_STATUS, 32'h4, 32'h0);
      wr(`ADDR_CTRL, 32'h2);
      wr(`ADDR_NRT, 32'h1);
      wr(`ADDR_CMD, `CMD_START_NRT);
      wait_ev(0, 5000);
      chk_rng(n, 4094, 4100);
      p2pMode <= 1'b1;
      wr(`ADDR_CMD, `CMD_START_NRT);
      rdc(`ADDR_STATUS, 32'h2, 32'h0);
      peerFieldOn <= 1'b1;
      @(posedge clk);
      peerFieldOn <= 1'b0;
      rdc(`ADDR_STATUS, 32'h1, 32'h1);
      repeat (70) @(posedge clk);
      p2pMode <= 1'b0;
      // Start in wake-up mode must be refused
      wakeupMode <= 1'b1;
      wr(`ADDR_CMD, `CMD_START_WUT);
      rdc(`ADDR_STATUS, 32'h8, 32'h0);
      wakeupMode <= 1'b0;
      wr(`ADDR_WUT, 32'h0);
      wr(`ADDR_CMD, `CMD_START_WUT);
      // The run flag is launched at the write edge; look one edge later
      @(posedge clk);
      chk(rcOscEn, 1'b1);
      wait_ev(2, 3000);
      chk_rng(n, 1240, 1300);
      rdc(`ADDR_FLAGS, 32'h4, 32'h4);
      rdc(`ADDR_STATUS, 32'h10, 32'h10);
      rdc(`ADDR_FLAGS, 32'h8, 32'h8);
      lpTargetMode <= 1'b1;
      wr(`ADDR_CMD, `CMD_START_MRT);
      repeat (500) @(posedge clk);
      chk(rxWatch, 1'b0);
      repeat (30) @(posedge clk);
      chk(rxWatch, 1'b1);
      // End-of-reception trigger; power-down holds the count until released
      wr(`ADDR_GPT, 32'h2);
      wr(`ADDR_CTRL, 32'h8);
      rxEof <= 1'b1;
      powerDown <= 1'b1;
      @(posedge clk);
      rxEof <= 1'b0;
      repeat (40) @(posedge clk);
      rdc(`ADDR_STATUS, 32'h4, 32'h4);
      powerDown <= 1'b0;
      wait_ev(1, 100);
      chk_rng(n, 16, 19);
      close_out();
   end
endmodule
`default_nettype wire
